//--- strap_cfg.svh
// Constants for the pin-strap configuration decoder.
// Assumes inclusion by bare name from the decoder and its package users.
`ifndef STRAP_CFG_SVH
`define STRAP_CFG_SVH

// ****************************************************************
// Decimation ratios
// ****************************************************************
`define DECIM_X32 11'h020
`define DECIM_X64 11'h040
`define DECIM_X128 11'h080
`define DECIM_X1024 11'h400

// ****************************************************************
// Modulator dividers and mode code boundaries
// ****************************************************************
`define MOD_DIV_FAST 6'h04
`define MOD_DIV_MEDIAN 6'h08
`define MOD_DIV_ECO 6'h20
`define MODE_ONESHOT_BASE 4'hC
`define MODE_CODE_ECO_OS 4'hC
`define MODE_CODE_MED_OS 4'hD
`define MODE_CODE_FAST_HALF 4'hE

// ****************************************************************
// Status header layout and reset values
// ****************************************************************
`define HDR_ERR_BIT 7
`define HDR_NOT_SETTLED_BIT 6
`define HDR_SATURATED_BIT 5
`define HDR_FILTER_BIT 4
`define WORD_HDR_W 8
`define WORD_DATA_W 24
`define AIN_PRECHARGE_RST 1'b1
`define REF_PRECHARGE_RST 1'b0

`endif

//--- strap_pkg.sv
// Types shared by the strap decoder and its users.
// Assumes no surroundings beyond a SystemVerilog compiler.
package strap_pkg;

  // ****************************************************************
  // Power mode, conversion style and filter type
  // ****************************************************************
  typedef enum logic [1:0] {
    POWER_ECO,
    POWER_MEDIAN,
    POWER_FAST
  } power_mode_t;

  typedef enum logic {
    CONV_STANDARD,
    CONV_ONESHOT
  } conv_style_t;

  typedef enum logic {
    FILTER_WIDEBAND,
    FILTER_SINC5
  } filter_t;

endpackage

//--- pin_strap_adc_config_decoder.sv
// Pin-strap configuration decoder for a multichannel converter.
// Assumes strap pins and sync inputs come from a host off this clock.
`timescale 1ns/1ps
`include "strap_cfg.svh"

module pin_strap_adc_config_decoder #(
  parameter int CHANNELS = 8
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ctrl_mode_pin,
  input wire logic filter_pin,
  input wire logic decim_sel_hi,
  input wire logic decim_sel_lo,
  input wire logic op_strap_b3,
  input wire logic op_strap_b2,
  input wire logic op_strap_b1,
  input wire logic op_strap_b0,
  input wire logic output_layout_b0,
  input wire logic output_layout_b1,
  input wire logic start_pin,
  input wire logic sync_in_pin,
  input wire logic crc_error,
  input wire logic mem_bit_flip,
  input wire logic clock_missing,
  input wire logic [CHANNELS-1:0] filter_not_settled,
  input wire logic [CHANNELS-1:0] filter_saturated,
  input wire logic [CHANNELS-1:0] channel_standby,
  input wire logic [CHANNELS*24-1:0] conv_result,
  output logic strap_mode,
  output strap_pkg::filter_t filter_sel,
  output logic [10:0] decim_ratio,
  output strap_pkg::power_mode_t power_mode,
  output logic [1:0] bias_scale,
  output logic [5:0] mod_clk_div,
  output logic [3:0] data_clock_divider,
  output strap_pkg::conv_style_t conv_style,
  output logic [1:0] output_layout,
  output logic ain_precharge_en,
  output logic ref_precharge_en,
  output logic [CHANNELS*32-1:0] channel_word
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  localparam int NPIN = 14;
  logic [NPIN-1:0] pin_meta;
  logic [NPIN-1:0] pin_sync;
  logic [NPIN-1:0] pin_raw;
  assign pin_raw = {ctrl_mode_pin, filter_pin, decim_sel_hi, decim_sel_lo,
                    op_strap_b3, op_strap_b2, op_strap_b1, op_strap_b0,
                    output_layout_b1, output_layout_b0, start_pin,
                    sync_in_pin, 2'h0};

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  logic s_ctrl;
  logic s_filter;
  logic [1:0] s_decim;
  logic [3:0] s_mode;
  logic [1:0] s_layout;
  logic s_start;
  logic s_sync;
  assign s_ctrl = pin_sync[13];
  assign s_filter = pin_sync[12];
  assign s_decim = pin_sync[11:10];
  assign s_mode = pin_sync[9:6];
  assign s_layout = pin_sync[5:4];
  assign s_start = pin_sync[3];
  assign s_sync = pin_sync[2];

  // ****************************************************************
  // Mode decode functions
  // ****************************************************************
  function automatic strap_pkg::power_mode_t decode_power(
    input logic [3:0] code
  );
    if (code >= `MODE_ONESHOT_BASE) begin
      unique case (code)
        `MODE_CODE_ECO_OS: decode_power = strap_pkg::POWER_ECO;
        `MODE_CODE_MED_OS: decode_power = strap_pkg::POWER_MEDIAN;
        default: decode_power = strap_pkg::POWER_FAST;
      endcase
    end else begin
      unique case (code[3:2])
        2'h0: decode_power = strap_pkg::POWER_ECO;
        2'h1: decode_power = strap_pkg::POWER_MEDIAN;
        default: decode_power = strap_pkg::POWER_FAST;
      endcase
    end
  endfunction

  function automatic logic [3:0] decode_serial_data_clock(input logic [3:0] code);
    if (code >= `MODE_ONESHOT_BASE) begin
      decode_serial_data_clock = (code == `MODE_CODE_FAST_HALF) ? 4'h2 : 4'h1;
    end else begin
      decode_serial_data_clock = 4'(4'h1 << code[1:0]);
    end
  endfunction

  function automatic logic [5:0] mod_div_of(
    input strap_pkg::power_mode_t pm
  );
    unique case (pm)
      strap_pkg::POWER_FAST: mod_div_of = `MOD_DIV_FAST;
      strap_pkg::POWER_MEDIAN: mod_div_of = `MOD_DIV_MEDIAN;
      default: mod_div_of = `MOD_DIV_ECO;
    endcase
  endfunction

  function automatic logic [10:0] decim_of(input logic [1:0] sel);
    unique case (sel)
      2'h0: decim_of = `DECIM_X32;
      2'h1: decim_of = `DECIM_X64;
      2'h2: decim_of = `DECIM_X128;
      default: decim_of = `DECIM_X1024;
    endcase
  endfunction

  // ****************************************************************
  // Capture control mode and load strap configuration
  // ****************************************************************
  // The first two cycles after reset release wait for the synchronisers, so
  // the straps seen are real pin levels rather than reset zeros.
  logic [1:0] boot_cnt;
  logic boot_load;
  logic start_d;
  logic sync_d;
  logic sync_accept;
  assign boot_load = (boot_cnt == 2'h2);
  assign sync_accept = strap_mode &&
                       ((s_start && !start_d) || (s_sync && !sync_d));

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      boot_cnt <= 2'h0;
      start_d <= 1'b0;
      sync_d <= 1'b0;
    end else begin
      if (boot_cnt != 2'h3) begin
        boot_cnt <= boot_cnt + 2'h1;
      end
      start_d <= s_start;
      sync_d <= s_sync;
    end
  end

  // Strap mode is the pin low, captured once; later changes are ignored.
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      strap_mode <= 1'b0;
    end else if (boot_load) begin
      strap_mode <= !s_ctrl;
    end
  end

  strap_pkg::power_mode_t next_power;
  assign next_power = decode_power(s_mode);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      filter_sel <= strap_pkg::FILTER_SINC5;
      decim_ratio <= `DECIM_X1024;
      power_mode <= strap_pkg::POWER_ECO;
      bias_scale <= 2'h0;
      mod_clk_div <= `MOD_DIV_ECO;
      data_clock_divider <= 4'h8;
      conv_style <= strap_pkg::CONV_STANDARD;
      output_layout <= 2'h0;
    end else if ((boot_load && !s_ctrl) || sync_accept) begin
      filter_sel <= s_filter ? strap_pkg::FILTER_SINC5
                             : strap_pkg::FILTER_WIDEBAND;
      decim_ratio <= decim_of(s_decim);
      power_mode <= next_power;
      bias_scale <= next_power;
      mod_clk_div <= mod_div_of(next_power);
      data_clock_divider <= decode_serial_data_clock(s_mode);
      conv_style <= (s_mode >= `MODE_ONESHOT_BASE) ?
                    strap_pkg::CONV_ONESHOT :
                    strap_pkg::CONV_STANDARD;
      output_layout <= s_layout;
    end
  end

  // ****************************************************************
  // Precharge buffers
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ain_precharge_en <= `AIN_PRECHARGE_RST;
      ref_precharge_en <= `REF_PRECHARGE_RST;
    end else if (strap_mode) begin
      ain_precharge_en <= `AIN_PRECHARGE_RST;
      ref_precharge_en <= `REF_PRECHARGE_RST;
    end
  end

  // ****************************************************************
  // Status header and output words
  // ****************************************************************
  // The fault flag is sticky until reset, since only a reset cures it.
  logic fault_seen;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fault_seen <= 1'b0;
    end else if (crc_error || mem_bit_flip || clock_missing) begin
      fault_seen <= 1'b1;
    end
  end

  logic [CHANNELS*32-1:0] next_word;
  always_comb begin
    next_word = '0;
    for (int ch = 0; ch < CHANNELS; ch++) begin
      if (!channel_standby[ch]) begin
        next_word[ch*32 + 24 + `HDR_ERR_BIT] =
          fault_seen || crc_error || mem_bit_flip || clock_missing;
        next_word[ch*32 + 24 + `HDR_NOT_SETTLED_BIT] =
          filter_not_settled[ch];
        next_word[ch*32 + 24 + `HDR_SATURATED_BIT] =
          filter_saturated[ch];
        next_word[ch*32 + 24 + `HDR_FILTER_BIT] =
          (filter_sel == strap_pkg::FILTER_WIDEBAND);
        next_word[ch*32 +: `WORD_DATA_W] =
          conv_result[ch*24 +: `WORD_DATA_W];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      channel_word <= '0;
    end else begin
      channel_word <= next_word;
    end
  end

endmodule // pin_strap_adc_config_decoder

//--- strap_cfg_monitor.sv
// Concurrent checks on the strap decoder ports.
// Assumes it is bound onto the decoder and sees only its ports.
`timescale 1ns/1ps
`include "strap_cfg.svh"
module strap_cfg_monitor #(
  parameter int CHANNELS = 8
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic start_pin,
  input wire logic sync_in_pin,
  input wire logic crc_error,
  input wire logic [CHANNELS-1:0] channel_standby,
  input wire logic [CHANNELS-1:0] filter_not_settled,
  input wire logic [CHANNELS*24-1:0] conv_result,
  input wire logic strap_mode,
  input wire logic [10:0] decim_ratio,
  input strap_pkg::power_mode_t power_mode,
  input wire logic [1:0] bias_scale,
  input wire logic [5:0] mod_clk_div,
  input wire logic [3:0] data_clock_divider,
  input strap_pkg::conv_style_t conv_style,
  input wire logic ain_precharge_en,
  input wire logic ref_precharge_en,
  input wire logic [CHANNELS*32-1:0] channel_word
);
  // ****
  // Checks
  // ****
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic [5:0] div_exp;
  assign div_exp = power_mode == strap_pkg::POWER_FAST ? `MOD_DIV_FAST :
    power_mode == strap_pkg::POWER_MEDIAN ? `MOD_DIV_MEDIAN : `MOD_DIV_ECO;
  // Five quiet samples cover the two-stage synchroniser and edge detect.
  sequence quiet_s;
    (strap_mode && !start_pin && !sync_in_pin) [*5];
  endsequence
  AST_HOLD: assert property (quiet_s |=> $stable(decim_ratio))
    else $error("config moved without sync");
  AST_MODDIV: assert property (mod_clk_div == div_exp)
    else $error("modulator divider wrong");
  AST_BIAS: assert property (bias_scale == power_mode)
    else $error("bias not tied to power mode");
  AST_PRE: assert property (ain_precharge_en && !ref_precharge_en)
    else $error("precharge defaults wrong");
  AST_DEC: assert property (decim_ratio inside {11'h020, 11'h040,
    11'h080, 11'h400}) else $error("decimation out of set");
  AST_OS: assert property (conv_style == strap_pkg::CONV_ONESHOT &&
    data_clock_divider == 4'h2 |-> power_mode == strap_pkg::POWER_FAST)
    else $error("halved one-shot not fast");
  AST_STBY: assert property (channel_standby[0] |=>
    channel_word[31:0] == 32'h0) else $error("standby word not zero");
  AST_RES: assert property (!channel_standby[0] |=>
    channel_word[23:0] == $past(conv_result[23:0]))
    else $error("result field wrong");
  AST_NS: assert property (!channel_standby[0] |=>
    channel_word[30] == $past(filter_not_settled[0]))
    else $error("not settled flag wrong");
  AST_FAULT: assert property (crc_error && !channel_standby[1] |->
    ##2 channel_word[63]) else $error("fault bit not set");
endmodule // strap_cfg_monitor
bind pin_strap_adc_config_decoder strap_cfg_monitor #(
  .CHANNELS(CHANNELS)) mon_u (.*);

//--- strap_host.sv
// Host model that drives the strap pins and the sync pulses.
// Assumes the bench calls its tasks; pins move at falling edges.
`timescale 1ns/1ps
module strap_host (
  input wire logic ref_clk,
  output logic ctrl_mode_pin,
  output logic filter_pin,
  output logic decim_sel_hi,
  output logic decim_sel_lo,
  output logic op_strap_b3,
  output logic op_strap_b2,
  output logic op_strap_b1,
  output logic op_strap_b0,
  output logic output_layout_b1,
  output logic output_layout_b0,
  output logic start_pin,
  output logic sync_in_pin
);
  // ****
  // Pin drive
  // ****
  // Word readout timing is not modelled; dividers are assumed to fit.
  initial begin
    {ctrl_mode_pin, start_pin, sync_in_pin} = 3'h0;
    set_pins(9'h000);
  end
  task automatic set_pins(input logic [8:0] s);
    {filter_pin, decim_sel_hi, decim_sel_lo, op_strap_b3, op_strap_b2,
      op_strap_b1, op_strap_b0, output_layout_b1, output_layout_b0} = s;
  endtask
  task automatic set_straps(input logic ctl, input logic [8:0] s);
    @(negedge ref_clk);
    ctrl_mode_pin = ctl;
    set_pins(s);
  endtask
  // A sync pulse on either input, raised three falling edges after the call and held for two.
  task automatic pulse(input logic use_sync);
    repeat (3) @(negedge ref_clk);
    if (use_sync) begin
      sync_in_pin = 1'b1;
    end else begin
      start_pin = 1'b1;
    end
    repeat (2) @(negedge ref_clk);
    {start_pin, sync_in_pin} = 2'h0;
  endtask
endmodule // strap_host

//--- pin_strap_adc_config_decoder_tb.sv
// Self-checking bench for the strap decoder.
// Assumes the host model drives straps and sync; bench drives the rest.
`timescale 1ns/1ps
module pin_strap_adc_config_decoder_tb;
  localparam int CH = 2;
  logic ref_clk = 1'b0, rstn = 1'b0, crc_error = 1'b0;
  logic mem_bit_flip = 1'b0, clock_missing = 1'b0;
  logic [CH-1:0] filter_not_settled = '0, filter_saturated = '0;
  logic [CH-1:0] channel_standby = '0;
  logic [CH*24-1:0] conv_result = '0;
  logic strap_mode, ain_precharge_en, ref_precharge_en;
  strap_pkg::filter_t filter_sel;
  strap_pkg::power_mode_t power_mode;
  strap_pkg::conv_style_t conv_style;
  logic [10:0] decim_ratio;
  logic [1:0] bias_scale, output_layout;
  logic [5:0] mod_clk_div;
  logic [3:0] data_clock_divider;
  logic [CH*32-1:0] channel_word;
  wire ctrl_mode_pin, filter_pin, decim_sel_hi, decim_sel_lo, op_strap_b3,
    op_strap_b2, op_strap_b1, op_strap_b0, output_layout_b1,
    output_layout_b0, start_pin, sync_in_pin;
  int num_errors = 0, comparisons = 0;
  pin_strap_adc_config_decoder #(.CHANNELS(CH)) dut_u (.*);
  strap_host host_u (.*);
  always #2 ref_clk = ~ref_clk;
  // ****
  // Compare and expectation tasks
  // ****
  task automatic check_cfg(string n, logic [10:0] e, logic [10:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic check_word(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic expect_cfg(logic [8:0] s);
    logic [3:0] m;
    logic [1:0] pm;
    m = s[5:2];
    pm = (m < 4'h4 || m == 4'hC) ? 2'h0 :
         (m < 4'h8 || m == 4'hD) ? 2'h1 : 2'h2;
    check_cfg("strap", 11'h1, 11'(strap_mode));
    check_cfg("filter", 11'(s[8]), 11'(filter_sel));
    check_cfg("decim", s[7:6] == 2'h3 ? 11'h400 : 11'h020 << s[7:6],
      decim_ratio);
    check_cfg("power", 11'(pm), 11'(power_mode));
    check_cfg("bias", 11'(pm), 11'(bias_scale));
    check_cfg("moddiv", pm == 2'h2 ? 11'h4 : pm == 2'h1 ? 11'h8 : 11'h20,
      11'(mod_clk_div));
    check_cfg("serial_data_clock", m < 4'hC ? 11'h1 << m[1:0] : m == 4'hE ? 11'h2 : 11'h1,
      11'(data_clock_divider));
    check_cfg("oneshot", 11'(m >= 4'hC), 11'(conv_style));
    check_cfg("layout", 11'(s[1:0]), 11'(output_layout));
    check_cfg("precharge", 11'h2,
      11'({ain_precharge_en, ref_precharge_en}));
  endtask
  task automatic complete_run;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ****
  // Tests
  // ****
  initial begin
    #(2000 * 4);
    num_errors++;
    complete_run;
  end
  initial begin
    logic [8:0] s;
    host_u.set_straps(1'b0, 9'h04F);
    repeat (20) @(negedge ref_clk);
    rstn = 1'b1;
    repeat (5) @(negedge ref_clk);
    expect_cfg(9'h04F);
    host_u.set_straps(1'b0, 9'h1FF);
    repeat (8) @(negedge ref_clk);
    expect_cfg(9'h04F);
    for (int i = 0; i < 16; i++) begin
      s = {i[0], i[1:0], i[3:0], i[3:2]};
      host_u.set_straps(1'b0, s);
      host_u.pulse(i[0]);
      repeat (5) @(negedge ref_clk);
      expect_cfg(s);
    end
    conv_result = 48'hABCDEF_123456;
    filter_not_settled = 2'b01;
    filter_saturated = 2'b10;
    channel_standby = 2'b01;
    @(negedge ref_clk);
    check_word("ch0", 32'h0, channel_word[31:0]);
    check_word("ch1", 32'h20ABCDEF, channel_word[63:32]);
    channel_standby = 2'b00;
    crc_error = 1'b1;
    @(negedge ref_clk);
    crc_error = 1'b0;
    repeat (2) @(negedge ref_clk);
    check_word("ch0", 32'hC0123456, channel_word[31:0]);
    check_word("ch1", 32'hA0ABCDEF, channel_word[63:32]);
    rstn = 1'b0;
    host_u.set_straps(1'b1, 9'h000);
    repeat (20) @(negedge ref_clk);
    rstn = 1'b1;
    host_u.pulse(1'b0);
    repeat (5) @(negedge ref_clk);
    check_cfg("strap", 11'h0, 11'(strap_mode));
    check_cfg("decim", 11'h400, decim_ratio);
    check_word("ch0", 32'h40123456, channel_word[31:0]);
    clock_missing = 1'b1;
    @(negedge ref_clk);
    clock_missing = 1'b0;
    repeat (2) @(negedge ref_clk);
    check_word("ch0", 32'hC0123456, channel_word[31:0]);
    complete_run;
  end
endmodule // pin_strap_adc_config_decoder_tb
